// ### hw/bct_term_ctrl.sv
/*
 * Bus-cycle termination controller. Runs one external bus cycle at a
 * time, samples size acknowledge, bus fault and halt at state n and
 * n+2 (one clock apart), and reports normal, halt, fault or retry.
 * Assumes the core offers one access at a time on i_req and waits for
 * o_done; all termination inputs are active high, already inverted.
 */
`timescale 1ns/1ps
`include "bct_params.svh"
module bct_term_ctrl (
	input wire logic i_clk, // system clock, 200 MHz
	input wire logic i_sys_rst, // synchronous reset, high
	input wire logic i_req, // core requests a bus cycle
	input wire logic [`BCT_ADDR_W-1:0] i_addr, // access address
	input wire logic [`BCT_FC_W-1:0] i_fc, // access function code
	input wire logic [`BCT_SIZE_W-1:0] i_size, // access size
	input wire logic i_write, // access is a write
	input wire logic i_prefetch, // access is an instruction prefetch
	input wire logic i_cache_fill, // read fills the instruction cache
	input wire logic i_word_used, // core uses the faulted prefetch word
	input wire logic i_word_discard, // branch or task switch drops it
	input wire logic [1:0] i_size_ack_pair, // size acknowledge pins
	input wire logic i_bus_fault_in, // bus fault pin
	input wire logic i_halt_in, // halt pin
	output logic o_addr_strobe, // address strobe, high when active
	output logic [`BCT_ADDR_W-1:0] o_addr, // address on the bus
	output logic [`BCT_FC_W-1:0] o_fc, // function code on the bus
	output logic [`BCT_SIZE_W-1:0] o_size, // size on the bus
	output logic o_write, // write direction on the bus
	output logic o_done, // pulse: cycle finished for the core
	output logic [2:0] o_outcome, // outcome code with o_done
	output logic o_fault_exc, // pulse: take bus-error exception
	output logic o_abort_instr, // pulse: abort current instruction
	output logic o_cache_inval, // pulse: invalidate fetched entry
	output logic o_halted // bus held by halt or in retry wait
);
	logic [3:0] pins_sync;
	logic ack_s;
	logic fault_s;
	logic halt_s;

	bct_sync #(.W(4)) u_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_size_ack_pair, i_bus_fault_in, i_halt_in}),
		.o_sync(pins_sync)
	);

	assign ack_s = |pins_sync[3:2];
	assign fault_s = pins_sync[1];
	assign halt_s = pins_sync[0];

	bct_pkg::bct_state_e state_reg, state_next;
	logic as_reg, as_next;
	logic [`BCT_ADDR_W-1:0] addr_reg, addr_next;
	logic [`BCT_FC_W-1:0] fc_reg, fc_next;
	logic [`BCT_SIZE_W-1:0] size_reg, size_next;
	logic write_reg, write_next;
	logic pf_reg, pf_next;
	logic fill_reg, fill_next;
	logic ack_n_reg, ack_n_next;
	logic halt_n_reg, halt_n_next;
	logic hold_retry_reg, hold_retry_next;
	logic [3:0] sync_cnt_reg, sync_cnt_next;
	logic done_reg, done_next;
	logic [2:0] outc_reg, outc_next;
	logic exc_reg, exc_next;
	logic abort_reg, abort_next;
	logic inval_reg, inval_next;
	logic halted_reg, halted_next;
	logic pend_pf_reg, pend_pf_next;
	logic fault_end;

	always_comb begin
		state_next = state_reg;
		as_next = as_reg;
		addr_next = addr_reg;
		fc_next = fc_reg;
		size_next = size_reg;
		write_next = write_reg;
		pf_next = pf_reg;
		fill_next = fill_reg;
		ack_n_next = ack_n_reg;
		halt_n_next = halt_n_reg;
		hold_retry_next = hold_retry_reg;
		sync_cnt_next = sync_cnt_reg;
		done_next = 1'b0;
		outc_next = outc_reg;
		exc_next = 1'b0;
		abort_next = 1'b0;
		inval_next = 1'b0;
		halted_next = halted_reg;
		pend_pf_next = pend_pf_reg;
		fault_end = 1'b0;
		case (state_reg)
			bct_pkg::BCT_IDLE: begin
				if (halt_s) begin
					halted_next = 1'b1;
				end else if (i_req) begin
					halted_next = 1'b0;
					as_next = 1'b1;
					addr_next = i_addr;
					fc_next = i_fc;
					size_next = i_size;
					write_next = i_write;
					pf_next = i_prefetch;
					fill_next = i_cache_fill & ~i_write;
					state_next = bct_pkg::BCT_WAIT_N;
				end
			end
			bct_pkg::BCT_WAIT_N: begin
				// first sample at even state n
				ack_n_next = ack_s;
				halt_n_next = halt_s;
				if (fault_s && halt_s) begin
					state_next = bct_pkg::BCT_RETRY_WAIT;
					as_next = 1'b0;
				end else if (fault_s) begin
					// fault alone, with or instead of ack
					fault_end = 1'b1;
				end else if (ack_s) begin
					state_next = bct_pkg::BCT_WAIT_N2;
				end
			end
			bct_pkg::BCT_WAIT_N2: begin
				// second sample at n+2 judges the pair
				if (fault_s && halt_s) begin
					// late retry
					state_next = bct_pkg::BCT_RETRY_WAIT;
					as_next = 1'b0;
				end else if (fault_s) begin
					// late fault after ack
					fault_end = 1'b1;
				end else begin
					as_next = 1'b0;
					done_next = 1'b1;
					if (halt_n_reg && halt_s) begin
						outc_next = `BCT_OUT_HALT;
						halted_next = 1'b1;
					end else begin
						outc_next = `BCT_OUT_NORMAL;
					end
					state_next = bct_pkg::BCT_IDLE;
				end
			end
			bct_pkg::BCT_RETRY_WAIT: begin
				// controls negated, no new cycle until both released
				if (!fault_s && !halt_s) begin
					sync_cnt_next = 4'(`BCT_SYNC_DELAY_CYC);
					state_next = bct_pkg::BCT_SYNC;
				end
			end
			bct_pkg::BCT_SYNC: begin
				if (sync_cnt_reg > 4'h1) begin
					sync_cnt_next = sync_cnt_reg - 4'h1;
				end else begin
					// repeat with the same address, code and size
					as_next = 1'b1;
					outc_next = `BCT_OUT_RETRY;
					state_next = bct_pkg::BCT_WAIT_N;
				end
			end
			default: begin
				state_next = bct_pkg::BCT_IDLE;
				as_next = 1'b0;
			end
		endcase
		if (fault_end) begin
			// normal end signalling, abort instruction unless prefetch
			as_next = 1'b0;
			done_next = 1'b1;
			outc_next = `BCT_OUT_FAULT;
			abort_next = ~pf_reg;
			state_next = bct_pkg::BCT_IDLE;
			inval_next = fill_reg;
			if (pf_reg) begin
				// deferred until the word is used
				pend_pf_next = 1'b1;
			end else begin
				exc_next = 1'b1;
			end
		end
		if (pend_pf_reg && !fault_end) begin
			if (i_word_discard) begin
				pend_pf_next = 1'b0;
			end else if (i_word_used) begin
				pend_pf_next = 1'b0;
				exc_next = 1'b1;
				abort_next = 1'b1;
			end
		end
		if (halted_reg && !halt_s && state_reg == bct_pkg::BCT_IDLE) begin
			halted_next = 1'b0;
		end
		// halted or retry-wait level registered so the output comes from one flop
		hold_retry_next = halted_next |
			(state_next == bct_pkg::BCT_RETRY_WAIT);
		if (i_sys_rst) begin
			state_next = bct_pkg::BCT_IDLE;
			as_next = 1'b0;
			addr_next = '0;
			fc_next = '0;
			size_next = '0;
			write_next = 1'b0;
			pf_next = 1'b0;
			fill_next = 1'b0;
			ack_n_next = 1'b0;
			halt_n_next = 1'b0;
			hold_retry_next = 1'b0;
			sync_cnt_next = 4'h0;
			done_next = 1'b0;
			outc_next = `BCT_OUT_NONE;
			exc_next = 1'b0;
			abort_next = 1'b0;
			inval_next = 1'b0;
			halted_next = 1'b0;
			pend_pf_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		state_reg <= state_next;
		as_reg <= as_next;
		addr_reg <= addr_next;
		fc_reg <= fc_next;
		size_reg <= size_next;
		write_reg <= write_next;
		pf_reg <= pf_next;
		fill_reg <= fill_next;
		ack_n_reg <= ack_n_next;
		halt_n_reg <= halt_n_next;
		hold_retry_reg <= hold_retry_next;
		sync_cnt_reg <= sync_cnt_next;
		done_reg <= done_next;
		outc_reg <= outc_next;
		exc_reg <= exc_next;
		abort_reg <= abort_next;
		inval_reg <= inval_next;
		halted_reg <= halted_next;
		pend_pf_reg <= pend_pf_next;
	end

	assign o_addr_strobe = as_reg;
	assign o_addr = addr_reg;
	assign o_fc = fc_reg;
	assign o_size = size_reg;
	assign o_write = write_reg;
	assign o_done = done_reg;
	assign o_outcome = outc_reg;
	assign o_fault_exc = exc_reg;
	assign o_abort_instr = abort_reg;
	assign o_cache_inval = inval_reg;
	assign o_halted = hold_retry_reg;
endmodule : bct_term_ctrl

// ### hw/bct_params.svh
/*
 * Constants for the bus-cycle termination controller: timing counts,
 * outcome codes and field widths.
 * Assumes the includer runs on a 200 MHz clock and reads the
 * termination inputs raw from pins.
 */
// Functional notes
// - sample termination inputs at even state n and again at n+2.
// - size ack alone with fault and halt negated ends cycle normally.
// - halt with or before ack, no fault: complete, then hold bus.
// - fault with halt negated ends cycle and raises a bus-error exception.
// - fault plus halt with or after ack: end cycle, retry after release.
// - ack then fault within one clock, halt negated, is still a fault.
// - timely fault overrides a concurrent size acknowledge.
// - fault aborts cycle and instruction; cycle ends with normal end signalling.
// - prefetch fault raises exception only when the word is used.
// - fault on a cache-fill read marks the fetched entry invalid.
// - for retry, negate controls until both released, repeat same access.
// - halt alone stops bus at next cycle boundary, never ends a cycle.
`ifndef BCT_PARAMS_SVH
`define BCT_PARAMS_SVH
`define BCT_CLK_PERIOD_PS 5000
`define BCT_SYNC_DELAY_NS 10
`define BCT_SYNC_DELAY_CYC \
	((`BCT_SYNC_DELAY_NS * 1000 + `BCT_CLK_PERIOD_PS - 1) / `BCT_CLK_PERIOD_PS)
`define BCT_ADDR_W 32
`define BCT_FC_W 3
`define BCT_SIZE_W 2
`define BCT_OUT_NONE 3'h0
`define BCT_OUT_NORMAL 3'h1
`define BCT_OUT_HALT 3'h2
`define BCT_OUT_FAULT 3'h3
`define BCT_OUT_RETRY 3'h4
`endif

// ### hw/bct_pkg.sv
/*
 * Types for the bus-cycle termination controller.
 * Assumes bct_params.svh is available on the include path.
 */
package bct_pkg;
	typedef enum logic [2:0] {
		BCT_IDLE,
		BCT_WAIT_N,
		BCT_WAIT_N2,
		BCT_HOLD,
		BCT_RETRY_WAIT,
		BCT_SYNC
	} bct_state_e;
endpackage : bct_pkg

// ### hw/bct_sync.sv
/*
 * Two-flop synchroniser for a bundle of pin levels.
 * Assumes inputs are asynchronous levels; output is two clocks late.
 */
`timescale 1ns/1ps
module bct_sync #(
	parameter int W = 4
) (
	input wire logic i_clk, // system clock
	input wire logic i_sys_rst, // synchronous reset, high
	input wire logic [W-1:0] i_async, // raw pin levels
	output logic [W-1:0] o_sync // synchronised levels
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = i_async;
		sync_next = meta_reg;
		if (i_sys_rst) begin
			meta_next = '0;
			sync_next = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign o_sync = sync_reg;
endmodule : bct_sync

// ### sim/bct_resp.sv
/* bct_resp: behavioural bus responder driving the termination pins.
   Assumes an active-high strobe; released pins settle low. */
`timescale 1ns/1ps
module bct_resp (
	input wire logic i_clk, // clock
	input wire logic i_strobe, // strobe
	input wire logic [2:0] i_mode, // answer kind
	output logic [1:0] o_ack, // ack pins
	output logic o_fault, // fault pin
	output logic o_halt // halt pin
);
	int cnt = 0;
	int rel = 0;
	logic [2:0] md = 3'h0;
	logic again = 1'b0;
	initial {o_ack, o_fault, o_halt} = 4'h0;
	// pins move once per clock so paired pins share one sample
	always @(negedge i_clk) begin
		if (i_strobe) begin
			cnt++;
			rel = 0;
			if (cnt == 1) begin
				md = again ? 3'h0 : i_mode;
				again = md == 3'h3 || md == 3'h5;
				o_ack = (md == 3'h1 || md == 3'h3) ? 2'h0 : 2'h3;
				o_fault = md == 3'h1 || md == 3'h3 || md == 3'h6;
				o_halt = md == 3'h3 || md == 3'h4;
			end
			if (cnt == 2 && (md == 3'h2 || md == 3'h5)) begin
				o_fault = 1'b1;
				o_halt = md == 3'h5;
			end
		end else begin
			cnt = 0;
			rel++;
			if (rel == 1) {o_ack, o_fault} = 3'h0;
			if (rel == 3) o_halt = 1'b0;
		end
	end
endmodule : bct_resp

// ### sim/bct_props.sv
/* bct_props: assertions on the termination controller ports.
   Assumes a bind onto bct_term_ctrl. */
`timescale 1ns/1ps
module bct_props (
	input wire logic i_clk, // clock
	input wire logic i_sys_rst, // reset
	input wire logic [1:0] i_size_ack_pair, // ack
	input wire logic i_bus_fault_in, // fault
	input wire logic i_halt_in, // halt
	input wire logic i_prefetch, // prefetch
	input wire logic i_cache_fill, // fill
	input wire logic o_addr_strobe, // strobe
	input wire logic o_done, // done
	input wire logic [2:0] o_outcome, // outcome
	input wire logic o_fault_exc, // exc
	input wire logic o_abort_instr, // abort
	input wire logic o_cache_inval, // inval
	input wire logic o_halted // halted
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_go;
		$rose(o_addr_strobe);
	endsequence
	sequence s_rty;
		$fell(o_addr_strobe) && !o_done;
	endsequence
	AST_DONE_END: assert property (
		o_done |-> !o_addr_strobe && $past(o_addr_strobe))
		else $error("done without end");
	AST_NORMAL: assert property (s_go ##1 (|i_size_ack_pair &&
		!i_bus_fault_in && !i_halt_in) [*3] |-> ##[1:3] o_done &&
		o_outcome == 3'h1) else $error("no normal end");
	AST_FAULT: assert property (s_go ##1 i_bus_fault_in &&
		!i_halt_in |-> ##[1:3] o_done && o_outcome == 3'h3)
		else $error("no fault end");
	AST_LATE: assert property (s_go ##0 |i_size_ack_pair &&
		!i_bus_fault_in && !i_halt_in ##1 i_bus_fault_in && !i_halt_in
		|-> ##[1:3] o_done && o_outcome == 3'h3) else $error("late");
	AST_RETRY: assert property (s_go ##1 i_bus_fault_in &&
		i_halt_in |-> ##[1:4] s_rty) else $error("no retry");
	AST_RETRY_WAIT: assert property (s_rty ##1
		(i_bus_fault_in || i_halt_in) |-> !o_addr_strobe)
		else $error("early retry");
	AST_HALT_BLOCK: assert property (s_go |->
		!($past(i_halt_in, 3) && $past(i_halt_in, 2)))
		else $error("start while halted");
	AST_HALT_OUT: assert property (
		o_done && o_outcome == 3'h2 |-> ##[0:1] o_halted)
		else $error("halt not held");
	AST_FAULT_SIDE: assert property (o_done &&
		o_outcome == 3'h3 && !i_prefetch |-> o_fault_exc &&
		o_abort_instr && o_cache_inval == i_cache_fill)
		else $error("fault side effects");
endmodule : bct_props
bind bct_term_ctrl bct_props PROPS (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_size_ack_pair(i_size_ack_pair), .i_bus_fault_in(i_bus_fault_in),
	.i_halt_in(i_halt_in), .i_prefetch(i_prefetch),
	.i_cache_fill(i_cache_fill), .o_addr_strobe(o_addr_strobe),
	.o_done(o_done), .o_outcome(o_outcome), .o_fault_exc(o_fault_exc),
	.o_abort_instr(o_abort_instr), .o_cache_inval(o_cache_inval),
	.o_halted(o_halted));

// ### sim/bus_cycle_termination_control_tb.sv
/* Testbench: every answer kind, retry and deferred prefetch fault.
   Assumes bct_resp answers on the termination pins. */
`timescale 1ns/1ps
module bus_cycle_termination_control_tb;
	logic clk = 0, rst = 1, req = 0, pf = 0, fill = 1, used = 0, disc = 0;
	logic [2:0] mode = 3'h0, oc;
	logic [1:0] ack;
	logic flt, hlt, stb, done, exc, abrt, inv, hltd;
	logic [31:0] addr = 32'h0, a_o;
	logic [2:0] fc_o;
	logic [1:0] sz_o;
	logic wr_o;
	int num_errors = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	bct_term_ctrl DUT (.i_clk(clk), .i_sys_rst(rst), .i_req(req),
		.i_addr(addr), .i_fc(3'h5), .i_size(2'h0), .i_write(1'b0),
		.i_prefetch(pf), .i_cache_fill(fill), .i_word_used(used),
		.i_word_discard(disc), .i_size_ack_pair(ack), .i_bus_fault_in(flt),
		.i_halt_in(hlt), .o_addr_strobe(stb), .o_addr(a_o), .o_fc(fc_o),
		.o_size(sz_o), .o_write(wr_o), .o_done(done), .o_outcome(oc),
		.o_fault_exc(exc), .o_abort_instr(abrt), .o_cache_inval(inv),
		.o_halted(hltd));
	bct_resp RSP (.i_clk(clk), .i_strobe(stb), .i_mode(mode), .o_ack(ack),
		.o_fault(flt), .o_halt(hlt));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task end_of_test;
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// one access, held until done; counts strobe starts
	task cyc(input logic [2:0] m, input logic [31:0] a,
		output logic [2:0] o, output logic [2:0] f, output int st);
		logic p;
		p = 0;
		st = 0;
		mode = m;
		addr = a;
		req = 1;
		repeat (60) begin
			@(negedge clk);
			if (stb === 1'b1 && !p) st++;
			p = stb;
			if (stb === 1'b1) chk(a_o, a);
			if (stb === 1'b1) chk({fc_o, sz_o, wr_o}, 6'h28);
			if (done === 1'b1) break;
		end
		chk(done, 1);
		o = oc;
		f = {exc, abrt, inv};
		req = 0;
	endtask : cyc
	task s_modes;
		logic [2:0] o, f;
		int st;
		logic [2:0] eo [7] = '{3'h1, 3'h3, 3'h3, 3'h1, 3'h2, 3'h1, 3'h3};
		for (int m = 0; m < 7; m++) begin
			cyc(m[2:0], 32'h1000 + m, o, f, st);
			chk(o, eo[m]);
			chk(f, (m == 1 || m == 2 || m == 6) ? 3'h7 : 3'h0);
			chk(st, (m == 3 || m == 5) ? 2 : 1);
			@(negedge clk);
			if (m == 4) chk({hltd, stb}, 2'h2);
			repeat (10) @(negedge clk);
		end
	endtask : s_modes
	task s_prefetch;
		logic [2:0] o, f;
		int st, k;
		pf = 1;
		fill = 0;
		for (int j = 0; j < 2; j++) begin
			cyc(3'h1, 32'h2000, o, f, st);
			chk(f, 3'h0);
			used = j == 1;
			disc = j == 0;
			@(negedge clk);
			used = 0;
			disc = 0;
			k = 0;
			repeat (4) begin
				k += exc === 1'b1;
				@(negedge clk);
			end
			chk(k, j);
			repeat (6) @(negedge clk);
		end
		pf = 0;
	endtask : s_prefetch
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		s_modes;
		s_prefetch;
		end_of_test;
	end
	// run needs about 200 cycles; allow twenty times that
	initial begin
		#20000;
		num_errors++;
		end_of_test;
	end
endmodule : bus_cycle_termination_control_tb
